// ===== hw/fsp_dev.sv
// flash device end: protection bits, lock, password and soft reset
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - program opcodes FD/E3 need write enable latch
// - host sends 24/32-bit sector address, zero-padded
// - program runs only if cs rises after address
// - busy flag set; completion clears latch, and clears busy only on success
// - program updates perr and busy like page program
// - dual die: E4 refused, addressed erase selects die
// - erase needs wel, exact 8 bits, sets all
// - erase suspend refused during protection erase
// - A7 repeats lock register every eight bits
// - host reads lock register even while busy
// - A6 clears lock after wel, exact frame
// - E7 outputs password, low byte, msb first
// - password mode makes password read undefined
// - E9 takes 64 bits, exact frame, then compares
// - mismatch sets perr, busy held until cleared
// - password match sets the lock bit
// - soft reset keeps freeze, lock, nonvolatile bits
// - soft reset restores bp only if freeze clear
// - reset acts at cs rise, then recovery time
// - failed power-up makes reset take init time
// - reset enable must directly precede reset
// - quad mode shifts four bits per clock
// - 99h resets only right after reset enable
module fsp_dev #(
  parameter int NSEC = 16,
  parameter bit DUAL_DIE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  fsp_link_if.dev lnk,
  input wire logic quad_all_mode,
  input wire logic addr_len_32,
  input wire logic [63:0] hidden_password,
  input wire logic password_mode_n,
  input wire logic [2:0] nv_bp,
  input wire logic bp_wr,
  input wire logic [2:0] bp_wdata,
  input wire logic freeze_set,
  input wire logic por_failed,
  output logic inprog_q,
  output logic wlatch_q,
  output logic perr_q,
  output logic lock_q,
  output logic freeze_q,
  output logic [2:0] bp_q,
  output logic [NSEC-1:0] secprot_q
);
  typedef enum logic [1:0] {FSP_IDLE, FSP_BUSY, FSP_ERR, FSP_RST} fsp_st_t;
  typedef enum logic [1:0] {FSP_PROG, FSP_ERASE, FSP_LCLR, FSP_UNLK} fsp_kind_t;

  localparam int SW = $clog2(NSEC);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage 0 feeds stage 1 only
  logic [2:0] sck_s;
  logic [2:0] cs_s;
  logic [3:0] io_s0;
  logic [3:0] io_s1;

  always_ff @(posedge ref_clk)
  begin
    sck_s <= {sck_s[1:0], lnk.sck};
    cs_s <= {cs_s[1:0], lnk.cs_n};
    io_s0 <= lnk.io_i;
    io_s1 <= io_s0;
  end

  wire sck_rise = sck_s[1] & ~sck_s[2];
  wire sck_fall = ~sck_s[1] & sck_s[2];
  wire cs_rise = cs_s[1] & ~cs_s[2];
  wire cs_low = ~cs_s[1];
  wire [6:0] step = quad_all_mode ? 7'd4 : 7'd1;

  //////////////////////////////////////////////////////////////////////////
  // input shifter: opcode, address or password, msb first
  logic [71:0] sh_q;
  logic [6:0] cnt_q;
  logic [7:0] op_q;
  wire [71:0] sh_d = quad_all_mode ? {sh_q[67:0], io_s1}
                                   : {sh_q[70:0], io_s1[0]};
  wire [6:0] cnt_d = cnt_q + step;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn || !cs_low)
      cnt_q <= 7'd0;
    else if (sck_rise && cnt_q < fsp_pkg::CNT_SAT)
      cnt_q <= cnt_d;
    if (cs_low && sck_rise)
      sh_q <= sh_d;
    if (!rstn)
      op_q <= 8'h00;
    else if (cs_low && sck_rise && cnt_d == fsp_pkg::OP_BITS)
      op_q <= sh_d[7:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // read-out words, first bit at bit 63; short registers repeat
  logic [63:0] pw_sw;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_swap
      // low byte leaves first, msb of each byte first
      assign pw_sw[63-8*gi -: 8] = hidden_password[8*gi +: 8];
    end
  endgenerate

  wire [7:0] status = {1'b0, perr_q, 1'b0, bp_q, wlatch_q, inprog_q};
  wire [7:0] lock_reg = {7'd0, lock_q};
  wire is_rdsr = op_q == fsp_pkg::OP_RDSR;
  wire is_lrd = op_q == fsp_pkg::OP_LOCK_RD;
  wire is_prd = op_q == fsp_pkg::OP_PASS_RD;
  wire rd_op = is_rdsr | is_lrd | is_prd; // status stays readable when busy
  // password mode hides the password: all ones shift out instead
  wire [63:0] pw_out = password_mode_n ? pw_sw : 64'hffff_ffff_ffff_ffff;
  wire [63:0] ow = is_prd ? pw_out
                 : is_lrd ? {8{lock_reg}}
                 : {8{status}};
  logic [5:0] k_q;
  logic [3:0] so_q;
  logic [3:0] soe_q;
  wire [63:0] ow_rot = ow << k_q;
  wire rd_phase = cs_low && rd_op && cnt_q >= fsp_pkg::OP_BITS;

  // output changes on falling sck; index wraps so data repeats
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || !cs_low)
      k_q <= 6'd0;
    else if (sck_fall && rd_phase)
      k_q <= k_q + step[5:0];
    if (!rstn || !rd_phase)
      so_q <= 4'h0;
    else if (sck_fall)
      so_q <= quad_all_mode ? ow_rot[63:60] : {2'b00, ow_rot[63], 1'b0};
    // enable only from the first falling edge: the host still drives
    // the lines until then in quad mode
    if (!rstn || !rd_phase)
      soe_q <= 4'h0;
    else if (sck_fall)
      soe_q <= quad_all_mode ? 4'hf : 4'h2;
  end
  assign lnk.d_io_o = so_q;
  assign lnk.d_io_oe = soe_q;

  //////////////////////////////////////////////////////////////////////////
  // command decode at chip-select rise; exact bit counts only
  fsp_st_t st_q;
  fsp_kind_t kind_q;
  logic [15:0] tmr_q;
  logic rst_en_q;
  logic [SW-1:0] sec_q;
  logic die_q;
  logic [63:0] pw_cap_q;
  // any command other than the reads, reset enable, reset and clear status in the error hold
  // is dropped while busy, which also refuses an erase suspend during protection erase
  wire idle = st_q == FSP_IDLE;
  wire got_cmd = cs_rise && cnt_q >= fsp_pkg::OP_BITS;
  wire c8 = cnt_q == fsp_pkg::OP_BITS;
  wire [6:0] addr_end = addr_len_32 ? fsp_pkg::ADDR4_END
                                    : fsp_pkg::ADDR3_END;
  wire prog_frame = (op_q == fsp_pkg::OP_PROG && cnt_q == addr_end) ||
    (op_q == fsp_pkg::OP_PROG4 && cnt_q == fsp_pkg::ADDR4_END);
  wire erase_frame = DUAL_DIE ?
    (op_q == fsp_pkg::OP_ERASE_ADDR && cnt_q == fsp_pkg::ADDR4_END) :
    (op_q == fsp_pkg::OP_ERASE && c8);
  wire go_wr_en = got_cmd && idle && op_q == fsp_pkg::OP_WR_EN && c8;
  wire go_prog = got_cmd && idle && wlatch_q && prog_frame;
  wire go_erase = got_cmd && idle && wlatch_q && erase_frame;
  wire go_lclr = got_cmd && idle && wlatch_q && c8 &&
    op_q == fsp_pkg::OP_LOCK_CLR;
  wire go_unlk = got_cmd && idle && op_q == fsp_pkg::OP_PASS_UNLK &&
    cnt_q == fsp_pkg::PASS_END;
  wire go_clear_status_cmd = got_cmd && (idle || st_q == FSP_ERR) && c8 &&
    op_q == fsp_pkg::OP_CLR_ST;
  wire go_soft_reset_enable_cmd = got_cmd && st_q != FSP_RST && c8 &&
    op_q == fsp_pkg::OP_RST_EN;
  wire go_rst = got_cmd && st_q != FSP_RST && c8 && rst_en_q &&
    op_q == fsp_pkg::OP_RST;
  wire pw_match = pw_cap_q == pw_sw;
  wire done = st_q == FSP_BUSY && tmr_q == 16'd0;
  wire [NSEC-1:0] die_mask = die_q ? {{(NSEC/2){1'b1}}, {(NSEC/2){1'b0}}}
                                   : {{(NSEC/2){1'b0}}, {(NSEC/2){1'b1}}};
  wire [NSEC-1:0] erase_mask = DUAL_DIE ? die_mask : {NSEC{1'b1}};

  // reset enable lives for exactly one following command
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      rst_en_q <= 1'b0;
    else if (got_cmd)
      rst_en_q <= go_soft_reset_enable_cmd;
  end

  // operation sequencer with its timer
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      st_q <= FSP_IDLE;
      kind_q <= FSP_PROG;
      tmr_q <= 16'd0;
      sec_q <= '0;
      die_q <= 1'b0;
      pw_cap_q <= 64'h0;
    end
    else if (go_rst)
    begin
      st_q <= FSP_RST;
      tmr_q <= por_failed ? fsp_pkg::PLI_CYC : fsp_pkg::RPH_CYC;
    end
    else
    begin
      case (st_q)
        FSP_IDLE:
        begin
          st_q <= (go_prog | go_erase | go_lclr | go_unlk) ? FSP_BUSY
                                                           : FSP_IDLE;
          kind_q <= go_prog ? FSP_PROG : go_erase ? FSP_ERASE
                  : go_lclr ? FSP_LCLR : FSP_UNLK;
          tmr_q <= go_prog ? fsp_pkg::PROG_CYC
                 : go_erase ? fsp_pkg::ERASE_CYC
                 : go_lclr ? fsp_pkg::LOCK_CYC : fsp_pkg::UNLK_CYC;
          sec_q <= sh_q[fsp_pkg::SEC_LSB +: SW];
          die_q <= sh_q[fsp_pkg::DIE_BIT];
          pw_cap_q <= sh_q[63:0];
        end
        FSP_BUSY:
        begin
          tmr_q <= tmr_q - 16'd1;
          if (done)
            st_q <= (kind_q == FSP_UNLK && !pw_match) ||
              (kind_q inside {FSP_PROG, FSP_ERASE} && !lock_q) ?
              FSP_ERR : FSP_IDLE;
        end
        FSP_ERR:
          st_q <= go_clear_status_cmd ? FSP_IDLE : FSP_ERR;
        FSP_RST:
        begin
          tmr_q <= tmr_q - 16'd1;
          if (tmr_q == 16'd0)
            st_q <= FSP_IDLE;
        end
        default:
          st_q <= FSP_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status bits and protection state
  wire ok_done = done && !((kind_q == FSP_UNLK && !pw_match) ||
    (kind_q inside {FSP_PROG, FSP_ERASE} && !lock_q));

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      inprog_q <= 1'b0;
      wlatch_q <= 1'b0;
      perr_q <= 1'b0;
      bp_q <= nv_bp;
      freeze_q <= 1'b0;
      lock_q <= password_mode_n; // password mode powers up locked
      secprot_q <= '1;
    end
    else
    begin
      // busy tracks any embedded activity, including the error hold
      inprog_q <= go_rst || (st_q != FSP_IDLE && !(ok_done || go_clear_status_cmd ||
        (st_q == FSP_RST && tmr_q == 16'd0)) ) ||
        go_prog || go_erase || go_lclr || go_unlk;
      if (go_wr_en)
        wlatch_q <= 1'b1;
      else if (done || go_rst)
        wlatch_q <= 1'b0;
      if (done && !ok_done)
        perr_q <= 1'b1;
      else if (go_clear_status_cmd || go_rst)
        perr_q <= 1'b0;
      if (freeze_set)
        freeze_q <= 1'b1; // soft reset leaves it alone
      if (go_rst && !freeze_q)
        bp_q <= nv_bp;
      else if (bp_wr && !freeze_q)
        bp_q <= bp_wdata;
      if (ok_done && kind_q == FSP_LCLR)
        lock_q <= 1'b0;
      else if (ok_done && kind_q == FSP_UNLK)
        lock_q <= 1'b1;
      if (ok_done && kind_q == FSP_PROG)
        secprot_q[sec_q] <= 1'b0;
      else if (ok_done && kind_q == FSP_ERASE)
        secprot_q <= secprot_q | erase_mask;
    end
  end
endmodule
`default_nettype wire

// ===== hw/fsp_pkg.sv
// constants shared by both ends of the protection command link
package fsp_pkg;
  // opcodes
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_CLR_ST = 8'h30;
  localparam logic [7:0] OP_PROG = 8'hfd;
  localparam logic [7:0] OP_PROG4 = 8'he3;
  localparam logic [7:0] OP_ERASE = 8'he4;
  localparam logic [7:0] OP_ERASE_ADDR = 8'hd4;
  localparam logic [7:0] OP_LOCK_RD = 8'ha7;
  localparam logic [7:0] OP_LOCK_CLR = 8'ha6;
  localparam logic [7:0] OP_PASS_RD = 8'he7;
  localparam logic [7:0] OP_PASS_UNLK = 8'he9;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  // frame lengths in bits
  localparam logic [6:0] OP_BITS = 7'd8;
  localparam logic [6:0] ADDR3_END = 7'd32;
  localparam logic [6:0] ADDR4_END = 7'd40;
  localparam logic [6:0] PASS_END = 7'd72;
  localparam logic [6:0] CNT_SAT = 7'd100;
  // status byte layout
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP = 2;
  localparam int ST_PERR = 6;
  // sector select and die select address bits
  localparam int SEC_LSB = 18;
  localparam int DIE_BIT = 31;
  // timing, printed in ns, converted to ref_clk cycles
  localparam int CLK_NS = 4;
  localparam int PROG_NS = 2000;
  localparam int ERASE_NS = 8000;
  localparam int LOCK_NS = 1000;
  localparam int UNLK_NS = 1000;
  localparam int RPH_NS = 400;
  localparam int PLI_NS = 4000;
  localparam logic [15:0] PROG_CYC = 16'(PROG_NS / CLK_NS);
  localparam logic [15:0] ERASE_CYC = 16'(ERASE_NS / CLK_NS);
  localparam logic [15:0] LOCK_CYC = 16'(LOCK_NS / CLK_NS);
  localparam logic [15:0] UNLK_CYC = 16'(UNLK_NS / CLK_NS);
  localparam logic [15:0] RPH_CYC = 16'(RPH_NS / CLK_NS);
  localparam logic [15:0] PLI_CYC = 16'(PLI_NS / CLK_NS);
  // host serial clock: half period in ref_clk cycles (64 ns period)
  localparam int SCK_HALF = 8;
endpackage

// ===== hw/fsp_link_if.sv
// serial link between the host controller and the flash device
`timescale 1ns/10ps
`default_nettype none
interface fsp_link_if;
  logic sck;
  logic cs_n;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io_i;
  // resolved pad level, idle lines pulled high
  assign io_i = (d_io_oe & d_io_o) | (h_io_oe & h_io_o) | ~(d_io_oe | h_io_oe);
  modport dev (input sck, input cs_n, input io_i,
               output d_io_o, output d_io_oe);
  modport host (output sck, output cs_n, output h_io_o, output h_io_oe,
                input io_i);
endinterface
`default_nettype wire

// ===== hw/fsp_host.sv
// host controller end: frames one command per request on the link
`timescale 1ns/10ps
`default_nettype none
module fsp_host #(
  parameter int HALF = fsp_pkg::SCK_HALF
) (
  input wire logic ref_clk,
  input wire logic rstn,
  fsp_link_if.host lnk,
  input wire logic quad_all_mode,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic [6:0] cmd_ntx,
  input wire logic [63:0] cmd_data,
  input wire logic [6:0] cmd_nrx,
  output logic busy_q,
  output logic done_q,
  output logic [63:0] rx_q
);
  typedef enum logic [1:0] {FSH_IDLE, FSH_RUN, FSH_END} fsh_st_t;

  fsh_st_t st_q;
  logic [7:0] div_q;
  logic sck_q;
  logic cs_n_q;
  logic [71:0] sh_q;
  logic [6:0] txl_q;
  logic [6:0] rxl_q;
  logic [3:0] out_q;
  logic [3:0] oe_q;
  logic [3:0] io_s0;
  logic [3:0] io_s1;

  //////////////////////////////////////////////////////////////////////////
  // read lines pass two flops; device answer lands well before rise
  always_ff @(posedge ref_clk)
  begin
    io_s0 <= lnk.io_i;
    io_s1 <= io_s0;
  end

  wire tick = div_q == 8'(HALF - 1);
  wire [6:0] step = quad_all_mode ? 7'd4 : 7'd1;
  wire [71:0] sh_nx = sh_q << step;
  wire [71:0] sh_ld = {cmd_op, cmd_data};
  wire rx_now = txl_q == 7'd0 && rxl_q != 7'd0;

  //////////////////////////////////////////////////////////////////////////
  // caller orders commands (write enable, reset enable, status polls);
  // each request is one complete frame
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      st_q <= FSH_IDLE;
      div_q <= 8'd0;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      sh_q <= 72'h0;
      txl_q <= 7'd0;
      rxl_q <= 7'd0;
      out_q <= 4'h0;
      oe_q <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rx_q <= 64'h0;
    end
    else
    begin
      done_q <= 1'b0;
      div_q <= (tick || st_q == FSH_IDLE) ? 8'd0 : div_q + 8'd1;
      case (st_q)
        FSH_IDLE:
          if (cmd_valid)
          begin
            st_q <= FSH_RUN;
            busy_q <= 1'b1;
            cs_n_q <= 1'b0;
            sh_q <= sh_ld;
            txl_q <= fsp_pkg::OP_BITS + cmd_ntx; // address msb first
            rxl_q <= cmd_nrx;
            rx_q <= 64'h0;
            out_q <= quad_all_mode ? sh_ld[71:68] : {3'b000, sh_ld[71]};
            oe_q <= quad_all_mode ? 4'hf : 4'h1;
          end
        FSH_RUN:
          if (tick && !sck_q)
          begin
            // rising edge: device samples, host samples read data
            sck_q <= 1'b1;
            if (txl_q != 7'd0)
              txl_q <= txl_q - step;
            if (rx_now)
            begin
              rxl_q <= rxl_q - step;
              rx_q <= quad_all_mode ? {rx_q[59:0], io_s1}
                                    : {rx_q[62:0], io_s1[1]};
            end
          end
          else if (tick)
          begin
            // falling edge: next bits out, turn lines round after tx
            sck_q <= 1'b0;
            sh_q <= sh_nx;
            out_q <= quad_all_mode ? sh_nx[71:68] : {3'b000, sh_nx[71]};
            if (txl_q == 7'd0)
              oe_q <= 4'h0;
            if (txl_q == 7'd0 && rxl_q == 7'd0)
              st_q <= FSH_END;
          end
        FSH_END:
          // cs rises right after the last bit, no extra clock
          if (tick)
          begin
            cs_n_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q <= FSH_IDLE;
          end
        default:
          st_q <= FSH_IDLE;
      endcase
    end
  end

  assign lnk.sck = sck_q;
  assign lnk.cs_n = cs_n_q;
  assign lnk.h_io_o = out_q;
  assign lnk.h_io_oe = oe_q;
endmodule
`default_nettype wire

// ===== tb/fsp_link_assertions.sv
// concurrent checks on the serial link and the device status bits
`timescale 1ns/10ps
`default_nettype none
module fsp_link_assertions (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] h_io_oe,
  input wire logic [3:0] d_io_oe,
  input wire logic inprog_q,
  input wire logic wlatch_q,
  input wire logic perr_q,
  input wire logic lock_q
);
  logic [15:0] busy_cnt_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////////
  // length of an embedded operation; recovery is the shortest one
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || !inprog_q)
      busy_cnt_q <= 16'h0000;
    else if (busy_cnt_q != 16'hffff)
      busy_cnt_q <= busy_cnt_q + 16'h0001;
  end
  //////////////////////////////////////////////////////////////////////////
  no_contention_a: assert property ((d_io_oe & h_io_oe) == 4'h0)
    else $error("host and device drive a line together");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock not low outside a frame");
  dev_release_a: assert property (cs_n [*6] |-> d_io_oe == 4'h0)
    else $error("device still drives after deselect");
  sck_high_a: assert property ($rose(sck) |-> sck [*8])
    else $error("serial clock high phase too short");
  busy_launch_a: assert property ($rose(inprog_q) |->
    cs_n && $past(cs_n, 3))
    else $error("operation started inside a frame");
  busy_hold_a: assert property ($rose(inprog_q) |-> inprog_q [*8])
    else $error("busy flag dropped too soon");
  busy_len_a: assert property ($fell(inprog_q) |->
    busy_cnt_q >= 16'd90)
    else $error("operation shorter than recovery");
  latch_done_a: assert property ($fell(inprog_q) && !$past(perr_q) |->
    ##[0:2] !wlatch_q)
    else $error("write enable kept after completion");
  perr_busy_a: assert property ($rose(perr_q) |-> inprog_q)
    else $error("error flagged without busy held");
  lock_set_a: assert property ($rose(lock_q) |-> ##[0:2] !inprog_q)
    else $error("lock set outside a completed unlock");
  cover property ($rose(perr_q));
  cover property ($rose(lock_q));
  cover property ($fell(inprog_q));
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench: host end drives device end over the link
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic ref_clk, rstn, quad, cv, bp_wr, frz, pmn, pf;
  logic inprog, wlatch, perr, lock, fz, busy, done;
  logic [7:0] op;
  logic [6:0] tx, nr;
  logic [63:0] dt, rx;
  logic [2:0] bp;
  logic [15:0] secprot;
  int num_errors = 0;
  int n_compared = 0;
  int c;
  localparam logic [63:0] PW = 64'h1122334455667788; // arbitrary
  fsp_link_if lnk();
  fsp_host u_fsp_host (.ref_clk(ref_clk), .rstn(rstn), .lnk(lnk.host),
    .quad_all_mode(quad), .cmd_valid(cv), .cmd_op(op), .cmd_ntx(tx),
    .cmd_data(dt), .cmd_nrx(nr), .busy_q(busy), .done_q(done), .rx_q(rx));
  fsp_dev #(.NSEC(16), .DUAL_DIE(1'b1)) u_fsp_dev (.ref_clk(ref_clk),
    .rstn(rstn), .lnk(lnk.dev), .quad_all_mode(quad), .addr_len_32(1'b0),
    .hidden_password(PW), .password_mode_n(pmn), .nv_bp(3'h2),
    .bp_wr(bp_wr), .bp_wdata(3'h5), .freeze_set(frz), .por_failed(pf),
    .inprog_q(inprog), .wlatch_q(wlatch), .perr_q(perr), .lock_q(lock),
    .freeze_q(fz), .bp_q(bp), .secprot_q(secprot));
  fsp_link_assertions u_fsp_link_assertions (.ref_clk(ref_clk),
    .rstn(rstn), .sck(lnk.sck), .cs_n(lnk.cs_n), .h_io_oe(lnk.h_io_oe),
    .d_io_oe(lnk.d_io_oe), .inprog_q(inprog), .wlatch_q(wlatch),
    .perr_q(perr),
    .lock_q(lock));
  //////////////////////////////////////////////////////////////////////////
  // tasks
  task automatic end_of_test;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // gap first so the device synchroniser sees select high
  task automatic cmd(input logic [7:0] o, input logic [6:0] t,
    input logic [63:0] d, input logic [6:0] r);
    int n;
    repeat (4) @(posedge ref_clk);
    op <= o;
    tx <= t;
    dt <= d;
    nr <= r;
    cv <= 1'b1;
    @(posedge ref_clk);
    cv <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20000)
    begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  // counts busy cycles; the first few are lost to the eight-cycle wait before counting
  task automatic idle(output int k);
    k = 0;
    repeat (8) @(negedge ref_clk);
    while (inprog === 1'b1 && k < 5000)
    begin
      @(negedge ref_clk);
      k++;
    end
  endtask
  task automatic chkn(input int k, input int l);
    chk(64'(k >= l - 20 && k <= l), 64'h1);
  endtask
  task automatic wen;
    cmd(fsp_pkg::OP_WR_EN, 7'd0, 64'h0, 7'd0);
  endtask
  task automatic srst;
    cmd(fsp_pkg::OP_RST_EN, 7'd0, 64'h0, 7'd0);
    cmd(fsp_pkg::OP_RST, 7'd0, 64'h0, 7'd0);
  endtask
  task automatic setbp(input logic f);
    @(posedge ref_clk);
    bp_wr <= 1'b1;
    frz <= f;
    @(posedge ref_clk);
    bp_wr <= 1'b0;
    frz <= 1'b0;
  endtask
  // password goes low byte first on the wire
  function automatic logic [63:0] bsw(input logic [63:0] v);
    for (int i = 0; i < 8; i++)
      bsw[8*i+:8] = v[56-8*i+:8];
  endfunction
  //////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial
  begin
    #200000;
    num_errors++;
    end_of_test();
  end
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {rstn, quad, cv, bp_wr, frz, pf} = 6'h00;
    pmn = 1'b1;
    op = 8'h00;
    tx = 7'h00;
    nr = 7'h00;
    dt = 64'h0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    chk({secprot, lock, bp}, {16'hffff, 1'b1, 3'h2});
    cmd(fsp_pkg::OP_PROG, 7'd24, {24'h140000, 40'h0}, 7'd0);
    idle(c);
    chk(secprot, 16'hffff);
    wen();
    cmd(fsp_pkg::OP_PROG, 7'd25, {24'h140000, 40'h0}, 7'd0);
    idle(c);
    chk({secprot, inprog, busy}, {16'hffff, 2'h0});
    cmd(fsp_pkg::OP_PROG, 7'd24, {24'h140000, 40'h0}, 7'd0);
    idle(c);
    chkn(c, fsp_pkg::PROG_CYC);
    chk({secprot[5], wlatch, inprog}, 3'h0);
    $display("test 1 done");
    wen();
    cmd(fsp_pkg::OP_ERASE, 7'd0, 64'h0, 7'd0);
    idle(c);
    chk({secprot[5], inprog}, 2'h0);
    wen();
    cmd(fsp_pkg::OP_ERASE_ADDR, 7'd32, 64'h0, 7'd0);
    idle(c);
    chkn(c, fsp_pkg::ERASE_CYC);
    chk(secprot, 16'hffff);
    wen();
    cmd(fsp_pkg::OP_PROG4, 7'd32, {32'h000c0000, 32'h0}, 7'd0);
    cmd(fsp_pkg::OP_RDSR, 7'd0, 64'h0, 7'd8);
    chk(rx[1:0], 2'h3);
    idle(c);
    chk(secprot, 16'hfff7);
    $display("test 2 done");
    cmd(fsp_pkg::OP_LOCK_RD, 7'd0, 64'h0, 7'd16);
    chk(rx[15:0], 16'h0101);
    cmd(fsp_pkg::OP_PASS_RD, 7'd0, 64'h0, 7'd72);
    chk(rx, 64'({bsw(PW), bsw(PW)} >> 56));
    wen();
    cmd(fsp_pkg::OP_LOCK_CLR, 7'd0, 64'h0, 7'd0);
    idle(c);
    chkn(c, fsp_pkg::LOCK_CYC);
    chk({lock, wlatch, inprog}, 3'h0);
    wen();
    cmd(fsp_pkg::OP_PROG, 7'd24, {24'h1c0000, 40'h0}, 7'd0);
    repeat (fsp_pkg::PROG_CYC + 20) @(negedge ref_clk);
    chk({secprot[7], perr, inprog}, 3'h7);
    cmd(fsp_pkg::OP_CLR_ST, 7'd0, 64'h0, 7'd0);
    idle(c);
    chk({perr, inprog}, 2'h0);
    $display("test 3 done");
    cmd(fsp_pkg::OP_PASS_UNLK, 7'd64, bsw(~PW), 7'd0);
    repeat (fsp_pkg::UNLK_CYC + 20) @(negedge ref_clk);
    chk({perr, inprog, lock}, 3'h6);
    srst();
    idle(c);
    chkn(c, fsp_pkg::RPH_CYC);
    chk({perr, inprog, lock}, 3'h0);
    cmd(fsp_pkg::OP_PASS_UNLK, 7'd64, bsw(PW), 7'd0);
    idle(c);
    chkn(c, fsp_pkg::UNLK_CYC);
    chk(lock, 1'b1);
    $display("test 4 done");
    setbp(1'b0);
    cmd(fsp_pkg::OP_RST_EN, 7'd0, 64'h0, 7'd0);
    cmd(fsp_pkg::OP_RDSR, 7'd0, 64'h0, 7'd8);
    cmd(fsp_pkg::OP_RST, 7'd0, 64'h0, 7'd0);
    idle(c);
    chk({61'(c), bp}, {61'h0, 3'h5});
    srst();
    idle(c);
    chk(bp, 3'h2);
    setbp(1'b1);
    pf <= 1'b1;
    srst();
    idle(c);
    chkn(c, fsp_pkg::PLI_CYC);
    chk({bp, fz, lock}, {3'h5, 2'h3});
    pf <= 1'b0;
    $display("test 5 done");
    pmn <= 1'b0;
    cmd(fsp_pkg::OP_PASS_RD, 7'd0, 64'h0, 7'd64);
    chk(rx, {64{1'b1}});
    quad <= 1'b1;
    wen();
    cmd(fsp_pkg::OP_RDSR, 7'd0, 64'h0, 7'd8);
    chk(rx[1], 1'b1);
    srst();
    idle(c);
    chk({wlatch, inprog}, 2'h0);
    $display("test 6 done");
    end_of_test();
  end
endmodule
`default_nettype wire
